/* rtl/sfse_pkg.sv */
package sfse_pkg;
    // status codes carried in periodic responses
    localparam logic [3:0] CODE_OK        = 4'h0;
    localparam logic [3:0] CODE_FACT_OTP  = 4'h2;
    localparam logic [3:0] CODE_USER_OTP  = 4'h3;
    localparam logic [3:0] CODE_REG_CRC   = 4'h4;
    localparam logic [3:0] CODE_ST_INCMP  = 4'h8;
    localparam logic [3:0] CODE_RESET     = 4'h8;

    // register byte addresses
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_STATUS   = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;
    localparam logic [11:0] ADDR_ACCEL    = 12'h010;
    localparam logic [11:0] ADDR_ST_DATA  = 12'h014;

    // control bits
    localparam int CTRL_PDC_EN  = 0;
    localparam int CTRL_ST_REQ  = 1;
    localparam int CTRL_LOCK_U  = 2;
    // status bits
    localparam int STAT_PENDING = 0;
    localparam int STAT_ST_ON   = 1;
    localparam int STAT_ERR     = 2;
    localparam int STAT_CODE_LO = 4;
    // interrupt events
    localparam int IRQ_W        = 4;
    localparam int EV_FACT      = 0;
    localparam int EV_USER      = 1;
    localparam int EV_REG       = 2;
    localparam int EV_ST_IGN    = 3;

    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [15:0] ST_DATA_RESET = 16'h0000;
endpackage : sfse_pkg

/* rtl/sfse_top.sv */
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: factory array CRC fault forces error response, status code 0010.
// RULE2: user array CRC fault with lock set forces error response, code 0011.
// RULE3: register CRC fault forces error, code 0100, only while collection enabled.
// RULE4: self-test request with collection disabled enables self-test, clears pending flag.
// RULE5: while self-test active, low/high results carry self-test data.
// RULE6: self-test request with collection enabled is ignored; data stays normal.
// RULE7: collection without self-test since reset: normal data, pending set, code 1000.
// RULE8: before self-test, command/response answers are normal, no substitution.
// RULE9: reset sets pending flag and status code 1000.
// RULE10: one code by priority: factory, user, register, then self-test pending.
module sfse_top (
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        NRST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // fault detectors
    input  wire logic        FACT_OTP_CRC_FAIL,
    input  wire logic        USER_OTP_CRC_FAIL,
    input  wire logic        USER_REG_CRC_FAIL,
    // signal chain
    input  wire logic [15:0] ACCEL_SAMPLE,
    input  wire logic [15:0] SELFTEST_SAMPLE,
    // response side
    input  wire logic        CMD_RESP_VALID,
    output logic             CMD_RESP_ERROR,
    output logic [3:0]       RESPONSE_STATUS_CODE,
    output logic             PDC_ERROR_RESPONSE,
    output logic [7:0]       ACCEL_RESULT_LOW,
    output logic [7:0]       ACCEL_RESULT_HIGH,
    output logic             SELFTEST_ENABLE,
    output logic             SELFTEST_PENDING_FLAG,
    output logic             IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic                          periodic_collect_enable_r;
    logic                          lock_user_r;
    logic                          selftest_on_r;
    logic                          selftest_pending_flag_r;
    logic [sfse_pkg::IRQ_W-1:0]    irq_stat_r;
    logic [sfse_pkg::IRQ_W-1:0]    irq_mask_r;
    logic [3:0]                    code_r;
    logic                          err_r;
    logic [15:0]                   result_r;
    logic [31:0]                   prdata_r;
    logic                          pready_r;
    logic                          irq_r;
    logic                          cr_err_r;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    wire        acc_first = PSEL & PENABLE & ~pready_r;
    wire        rd_launch = acc_first & ~PWRITE;
    wire        acc_wr    = PSEL & PENABLE & PWRITE & pready_r;
    wire        hit_ctrl  = PADDR == sfse_pkg::ADDR_CTRL;
    wire        hit_stat  = PADDR == sfse_pkg::ADDR_STATUS;
    wire        hit_istat = PADDR == sfse_pkg::ADDR_IRQ_STAT;
    wire        hit_imask = PADDR == sfse_pkg::ADDR_IRQ_MASK;
    wire        hit_accel = PADDR == sfse_pkg::ADDR_ACCEL;
    wire        hit_stdat = PADDR == sfse_pkg::ADDR_ST_DATA;
    wire        wr_ctrl   = acc_wr & hit_ctrl;
    wire        st_req    = wr_ctrl & PWDATA[sfse_pkg::CTRL_ST_REQ];
    wire        st_accept = st_req & ~periodic_collect_enable_r; // see RULE4
    wire        st_ignore = st_req & periodic_collect_enable_r;  // see RULE6

    ////////////////////////////////////////////////////////////////////////
    // fault priority
    wire        user_fault = USER_OTP_CRC_FAIL & lock_user_r;                  // see RULE2
    wire        reg_fault  = USER_REG_CRC_FAIL & periodic_collect_enable_r;    // see RULE3
    wire        any_err    = FACT_OTP_CRC_FAIL | user_fault | reg_fault;
    wire        pend_nxt   = selftest_pending_flag_r & ~st_accept;
    // fixed order: factory, user, register, pending self-test
    wire [3:0]  code_nxt   = FACT_OTP_CRC_FAIL ? sfse_pkg::CODE_FACT_OTP :      // see RULE1 see RULE10
                             user_fault        ? sfse_pkg::CODE_USER_OTP :      // see RULE10
                             reg_fault         ? sfse_pkg::CODE_REG_CRC :       // see RULE10
                             pend_nxt          ? sfse_pkg::CODE_ST_INCMP :      // see RULE7
                                                 sfse_pkg::CODE_OK;
    wire        st_on_nxt  = selftest_on_r | st_accept;
    // results follow self-test data only when enabled in initialization
    wire [15:0] result_nxt = st_on_nxt ? SELFTEST_SAMPLE : ACCEL_SAMPLE;       // see RULE5 see RULE6

    wire [sfse_pkg::IRQ_W-1:0] events;
    assign events[sfse_pkg::EV_FACT]   = FACT_OTP_CRC_FAIL;
    assign events[sfse_pkg::EV_USER]   = user_fault;
    assign events[sfse_pkg::EV_REG]    = reg_fault;
    assign events[sfse_pkg::EV_ST_IGN] = st_ignore;
    wire [sfse_pkg::IRQ_W-1:0] w1c = (acc_wr & hit_istat) ? PWDATA[sfse_pkg::IRQ_W-1:0] : '0;
    // set beats clear so an event in the clearing cycle is kept
    wire [sfse_pkg::IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~w1c) | events;

    wire [31:0] status_word = {24'h00_0000, code_r, 1'b0, err_r, selftest_on_r, selftest_pending_flag_r};
    wire [31:0] rd_mux = hit_ctrl  ? {29'h0, lock_user_r, 1'b0, periodic_collect_enable_r} :
                         hit_stat  ? status_word :
                         hit_istat ? {28'h0, irq_stat_r} :
                         hit_imask ? {28'h0, irq_mask_r} :
                         hit_accel ? {16'h0000, result_r} :
                         hit_stdat ? {31'h0, selftest_on_r} :
                                     sfse_pkg::ZERO32;

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, answer in the second access cycle
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= acc_first;
        end
    end

    // zero outside the answer cycle so stale data never lingers on the bus
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            prdata_r <= sfse_pkg::ZERO32;
        end else begin
            prdata_r <= rd_launch ? rd_mux : sfse_pkg::ZERO32;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            cr_err_r <= 1'b0;
        end else begin
            cr_err_r <= 1'b0 & CMD_RESP_VALID; // see RULE8
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            periodic_collect_enable_r <= 1'b0;
        end else if (wr_ctrl) begin
            periodic_collect_enable_r <= PWDATA[sfse_pkg::CTRL_PDC_EN];
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            lock_user_r <= 1'b0;
        end else if (wr_ctrl) begin
            lock_user_r <= PWDATA[sfse_pkg::CTRL_LOCK_U];
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            irq_mask_r <= '0;
        end else if (acc_wr & hit_imask) begin
            irq_mask_r <= PWDATA[sfse_pkg::IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // self-test: sticky until reset, software has no way back out
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            selftest_on_r <= 1'b0;
        end else begin
            selftest_on_r <= st_on_nxt;                       // see RULE4
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            selftest_pending_flag_r <= 1'b1;                  // see RULE9
        end else begin
            selftest_pending_flag_r <= pend_nxt;              // see RULE4 see RULE7
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault reporting
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            code_r <= sfse_pkg::CODE_RESET;                   // see RULE9
        end else begin
            code_r <= code_nxt;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            err_r <= 1'b0;
        end else begin
            err_r <= any_err;                                 // see RULE1 see RULE2 see RULE3
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            result_r <= sfse_pkg::ST_DATA_RESET;
        end else begin
            result_r <= result_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: one sticky flag per event
    for (genvar i = 0; i < sfse_pkg::IRQ_W; i++) begin : g_irq_bit
        always_ff @(posedge CLOCK or negedge NRST) begin
            if (!NRST) begin
                irq_stat_r[i] <= 1'b0;
            end else begin
                irq_stat_r[i] <= irq_stat_nxt[i];
            end
        end
    end

    // built from the next status so the line rises with the flag, not a cycle later
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign PRDATA                = prdata_r;
    assign PREADY                = pready_r;
    assign PSLVERR               = 1'b0;
    assign CMD_RESP_ERROR        = cr_err_r;
    assign RESPONSE_STATUS_CODE  = code_r;
    assign PDC_ERROR_RESPONSE    = err_r;
    assign ACCEL_RESULT_LOW      = result_r[7:0];
    assign ACCEL_RESULT_HIGH     = result_r[15:8];
    assign SELFTEST_ENABLE       = selftest_on_r;
    assign SELFTEST_PENDING_FLAG = selftest_pending_flag_r;
    assign IRQ                   = irq_r;

endmodule : sfse_top

/* testbench/sfse_sva.sv */
`timescale 1ns/1ps
module sfse_sva (
    // watched ports
    input wire logic        CLOCK, NRST, PSEL, PENABLE, PREADY, PSLVERR, CMD_RESP_ERROR,
    input wire logic        FACT_OTP_CRC_FAIL, USER_OTP_CRC_FAIL, USER_REG_CRC_FAIL,
    input wire logic        PDC_ERROR_RESPONSE, SELFTEST_ENABLE, SELFTEST_PENDING_FLAG,
    input wire logic [15:0] ACCEL_SAMPLE, SELFTEST_SAMPLE,
    input wire logic [7:0]  ACCEL_RESULT_LOW, ACCEL_RESULT_HIGH,
    input wire logic [3:0]  RESPONSE_STATUS_CODE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    wire logic [15:0] res = {ACCEL_RESULT_HIGH, ACCEL_RESULT_LOW};
    wire logic [3:0]  code = RESPONSE_STATUS_CODE;
    wire logic        err = PDC_ERROR_RESPONSE;
    wire logic        nof = !FACT_OTP_CRC_FAIL && !USER_OTP_CRC_FAIL && !USER_REG_CRC_FAIL;
    fact_code_a: assert property (FACT_OTP_CRC_FAIL |=> code == 4'h2 && err)
        else $error("factory fault code wrong");
    user_code_a: assert property ((!FACT_OTP_CRC_FAIL && USER_OTP_CRC_FAIL ##1 err) |-> code inside {4'h3, 4'h4})
        else $error("user fault code wrong");
    no_fault_a: assert property (nof |=> !err)
        else $error("error response without fault");
    err_prio_a: assert property (err |-> code inside {4'h2, 4'h3, 4'h4})
        else $error("error response with wrong code");
    pend_code_a: assert property ((nof ##1 SELFTEST_PENDING_FLAG) |-> code == 4'h8)
        else $error("pending code wrong");
    st_sticky_a: assert property (SELFTEST_ENABLE |=> SELFTEST_ENABLE && !SELFTEST_PENDING_FLAG)
        else $error("self-test state lost");
    st_data_a: assert property (SELFTEST_ENABLE |=> res == $past(SELFTEST_SAMPLE))
        else $error("self-test data wrong");
    norm_data_a: assert property ((!SELFTEST_ENABLE ##1 !SELFTEST_ENABLE && $past(NRST))
        |-> res == $past(ACCEL_SAMPLE))
        else $error("normal data wrong");
    cmd_err_a: assert property (!CMD_RESP_ERROR)
        else $error("command answer substituted");
    // one wait state, never an error
    apb_wait_a: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY && !PSLVERR)
        else $error("apb answer timing wrong");
endmodule : sfse_sva
bind sfse_top sfse_sva u_sva (.CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CMD_RESP_ERROR(CMD_RESP_ERROR), .FACT_OTP_CRC_FAIL(FACT_OTP_CRC_FAIL),
    .USER_OTP_CRC_FAIL(USER_OTP_CRC_FAIL), .USER_REG_CRC_FAIL(USER_REG_CRC_FAIL),
    .PDC_ERROR_RESPONSE(PDC_ERROR_RESPONSE), .SELFTEST_ENABLE(SELFTEST_ENABLE),
    .SELFTEST_PENDING_FLAG(SELFTEST_PENDING_FLAG), .ACCEL_SAMPLE(ACCEL_SAMPLE), .SELFTEST_SAMPLE(SELFTEST_SAMPLE),
    .ACCEL_RESULT_LOW(ACCEL_RESULT_LOW), .ACCEL_RESULT_HIGH(ACCEL_RESULT_HIGH),
    .RESPONSE_STATUS_CODE(RESPONSE_STATUS_CODE));

/* testbench/sfse_cmd_master.sv */
`timescale 1ns/1ps
module sfse_cmd_master (
    // clock and reset
    input  wire logic CLOCK,
    input  wire logic NRST,
    // command side
    output logic      cmd_valid,
    input  wire logic cmd_error,
    output int        bad_count
);
    logic [1:0] gap_r;
    logic       seen_r;
    // one command every fourth cycle, so answers never overlap
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            gap_r <= 2'h0;
            cmd_valid <= 1'b0;
            seen_r <= 1'b0;
            bad_count <= 0;
        end else begin
            gap_r <= gap_r + 2'h1;
            cmd_valid <= gap_r == 2'h3;
            // the answer stands one edge after the command was sampled
            seen_r <= cmd_valid;
            if (seen_r && cmd_error !== 1'b0) bad_count <= bad_count + 1;
        end
    end
endmodule : sfse_cmd_master

/* testbench/sensor_fault_status_encoder_tb.sv */
`timescale 1ns/1ps
module sensor_fault_status_encoder_tb;
    logic        CLOCK = 1'b0, NRST = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic        FACT_OTP_CRC_FAIL = 1'b0, USER_OTP_CRC_FAIL = 1'b0, USER_REG_CRC_FAIL = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic [15:0] ACCEL_SAMPLE = 16'hA5C3, SELFTEST_SAMPLE = 16'h3C5A;
    logic [7:0]  ACCEL_RESULT_LOW, ACCEL_RESULT_HIGH;
    logic [3:0]  RESPONSE_STATUS_CODE;
    logic        PREADY, PSLVERR, CMD_RESP_VALID, CMD_RESP_ERROR, PDC_ERROR_RESPONSE, SELFTEST_ENABLE;
    logic        SELFTEST_PENDING_FLAG, IRQ;
    int          miscompares = 0, check_count = 0, bad_count;
    initial forever #4 CLOCK = ~CLOCK;
    sfse_top uut (.CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .FACT_OTP_CRC_FAIL(FACT_OTP_CRC_FAIL), .USER_OTP_CRC_FAIL(USER_OTP_CRC_FAIL),
        .USER_REG_CRC_FAIL(USER_REG_CRC_FAIL), .ACCEL_SAMPLE(ACCEL_SAMPLE), .SELFTEST_SAMPLE(SELFTEST_SAMPLE),
        .CMD_RESP_VALID(CMD_RESP_VALID), .CMD_RESP_ERROR(CMD_RESP_ERROR),
        .RESPONSE_STATUS_CODE(RESPONSE_STATUS_CODE), .PDC_ERROR_RESPONSE(PDC_ERROR_RESPONSE),
        .ACCEL_RESULT_LOW(ACCEL_RESULT_LOW), .ACCEL_RESULT_HIGH(ACCEL_RESULT_HIGH),
        .SELFTEST_ENABLE(SELFTEST_ENABLE), .SELFTEST_PENDING_FLAG(SELFTEST_PENDING_FLAG), .IRQ(IRQ));
    sfse_cmd_master u_host (.CLOCK(CLOCK), .NRST(NRST), .cmd_valid(CMD_RESP_VALID),
        .cmd_error(CMD_RESP_ERROR), .bad_count(bad_count));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // request held until the edge that samples pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLOCK);
        {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, wr, a, d};
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        @(posedge CLOCK);
        while (PREADY !== 1'b1) begin
            n++;
            if (n > 20) begin
                miscompares++;
                tally_and_finish;
            end
            @(posedge CLOCK);
        end
        rd = PRDATA;
        {PSEL, PENABLE} <= 2'b00;
    endtask : apb
    task automatic flt(input logic [2:0] f, input logic [3:0] code, input logic err);
        @(posedge CLOCK);
        {FACT_OTP_CRC_FAIL, USER_OTP_CRC_FAIL, USER_REG_CRC_FAIL} <= f;
        ACCEL_SAMPLE <= ACCEL_SAMPLE + 16'h1111;
        SELFTEST_SAMPLE <= SELFTEST_SAMPLE - 16'h0101;
        repeat (2) @(posedge CLOCK);
        #1;
        chk("status code", code, RESPONSE_STATUS_CODE);
        chk("error response", err, PDC_ERROR_RESPONSE);
    endtask : flt
    initial begin
        repeat (3) @(posedge CLOCK);
        #1;
        chk("reset code", 4'h8, RESPONSE_STATUS_CODE);
        chk("reset pending", 1'b1, SELFTEST_PENDING_FLAG);
        @(posedge CLOCK);
        NRST <= 1'b1;
        flt(3'b001, 4'h8, 1'b0);
        apb(1'b1, sfse_pkg::ADDR_CTRL, 32'h1);
        flt(3'b001, 4'h4, 1'b1);
        flt(3'b011, 4'h4, 1'b1);
        flt(3'b000, 4'h8, 1'b0);
        chk("normal data", ACCEL_SAMPLE, {ACCEL_RESULT_HIGH, ACCEL_RESULT_LOW});
        apb(1'b1, sfse_pkg::ADDR_CTRL, 32'h7);
        #1 chk("ignored request", 1'b0, SELFTEST_ENABLE);
        flt(3'b011, 4'h3, 1'b1);
        chk("data after ignore", ACCEL_SAMPLE, {ACCEL_RESULT_HIGH, ACCEL_RESULT_LOW});
        flt(3'b111, 4'h2, 1'b1);
        flt(3'b000, 4'h8, 1'b0);
        apb(1'b0, sfse_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("irq status", 32'hF, rd);
        #1 chk("irq masked", 1'b0, IRQ);
        apb(1'b1, sfse_pkg::ADDR_IRQ_MASK, 32'h8);
        repeat (2) @(posedge CLOCK);
        #1 chk("irq raised", 1'b1, IRQ);
        apb(1'b1, sfse_pkg::ADDR_IRQ_STAT, 32'hF);
        repeat (2) @(posedge CLOCK);
        #1 chk("irq cleared", 1'b0, IRQ);
        // request only honoured while collection is off
        apb(1'b1, sfse_pkg::ADDR_CTRL, 32'h4);
        apb(1'b1, sfse_pkg::ADDR_CTRL, 32'h6);
        flt(3'b000, 4'h0, 1'b0);
        chk("self-test on", 1'b1, SELFTEST_ENABLE);
        chk("pending cleared", 1'b0, SELFTEST_PENDING_FLAG);
        chk("self-test data", SELFTEST_SAMPLE, {ACCEL_RESULT_HIGH, ACCEL_RESULT_LOW});
        apb(1'b0, sfse_pkg::ADDR_STATUS, 32'h0);
        chk("status word", 32'h2, rd);
        apb(1'b0, sfse_pkg::ADDR_CTRL, 32'h0);
        chk("control word", 32'h4, rd);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped read", 32'h0, rd);
        chk("command errors", 32'h0, bad_count);
        // second reset in mid-run must drop the sticky self-test state
        @(posedge CLOCK);
        NRST <= 1'b0;
        repeat (2) @(posedge CLOCK);
        #1 chk("rerun code", 4'h8, RESPONSE_STATUS_CODE);
        chk("rerun pending", 1'b1, SELFTEST_PENDING_FLAG);
        chk("rerun self-test", 1'b0, SELFTEST_ENABLE);
        @(posedge CLOCK);
        NRST <= 1'b1;
        flt(3'b000, 4'h8, 1'b0);
        chk("rerun data", ACCEL_SAMPLE, {ACCEL_RESULT_HIGH, ACCEL_RESULT_LOW});
        tally_and_finish;
    end
endmodule : sensor_fault_status_encoder_tb
